// file: include/lpm_pkg.sv
// Constants for the low power mode controller.
// Assumes a 10 MHz CPU clock and a 32-bit AXI4-Lite register bus.
package lpm_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;

	// clock_ctrl_status_reg style control bits
	localparam int CTRL_TB_IRQ_EN_BIT  = 0;  // timebase_irq_enable
	localparam int CTRL_SLOW_BIT       = 1;  // reduced-frequency slow mode
	localparam int CTRL_WDG_HALT_BIT   = 2;  // watchdog_halt_option
	localparam int CTRL_WDG_EN_BIT     = 3;  // watchdog running
	localparam logic [3:0] CTRL_RESET  = 4'h0;

	localparam int STATUS_STATE_LSB    = 0;  // six state bits
	localparam int STATUS_CAUSE_BIT    = 6;  // 1 = last halt wake was by reset
	localparam int STATUS_COUNT_LSB    = 8;  // remaining delay count

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int STAB_CYCLES = 4096;       // oscillator start-up, CPU cycles

	// ------------------------------------------------------------------
	// Bus answers
	// ------------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------------
	// Power states
	// ------------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_RUN       = 6'h01,
		ST_WAIT      = 6'h02,
		ST_SLOW_WAIT = 6'h04,
		ST_ACT_HALT  = 6'h08,
		ST_HALT      = 6'h10,
		ST_STARTUP   = 6'h20
	} lpm_state_t;

endpackage : lpm_pkg

// file: verilog/lpm_controller.sv
// Low power mode controller: wait, active halt and full halt sequencing,
// clock gating, start-up delay and watchdog interplay.
// Assumes the CPU core pulses instruction strobes and services the
// returned wake commands; all inputs are synchronous to clk.
//
// Overview of operation
// - Wait instruction stops the CPU clock; peripherals keep their clock.
// - Entering wait clears the interrupt mask; nothing else is changed.
// - Wait lasts until any interrupt or reset, then vectors there.
// - Servicing a wake interrupt pushes condition codes and sets mask.
// - Halt goes to full halt if timebase enable is 0, else active.
// - Active halt exits only on timebase, wake-capable irq, or reset.
// - Active halt exit waits 4096 cycles before service or reset vector.
// - Entering active halt clears the mask; pending irq wakes at once.
// - Active halt keeps only oscillator and timebase counter clocked.
// - With timebase enable set, active halt never raises watchdog reset.
// - Full halt exit restarts oscillator, then waits 4096 cycles.
// - Entering full halt forces the mask to 0; pending wakes at once.
// - Full halt stops oscillator, CPU and all on-chip peripherals.
// - Halt with watchdog on may reset, per halt option bit.
// - Timebase and clock-security wake active halt only; external both.
// - Wait entered in slow mode becomes slow-wait keeping slow clock.
`timescale 1ns/1ps

module lpm_controller #(
	parameter int STAB_CYCLES = lpm_pkg::STAB_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        srst,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// CPU core side
	input  wire logic        waitForInterruptInstr,
	input  wire logic        haltInstr,
	input  wire logic        extIrq,
	input  wire logic        timebaseIrq,
	input  wire logic        clockSecIrq,
	input  wire logic        periphIrq,
	input  wire logic        resetReq,
	output logic             cpuClkEn,
	output logic             periphClkEn,
	output logic             oscEnable,
	output logic             timebaseClkEn,
	output logic             slowClkSel,
	output logic             intMaskClear,
	output logic             serviceIrq,
	output logic             fetchResetVector,
	output logic             watchdogReset,
	output logic             watchdogSuspend
);

	localparam int CW = $clog2(STAB_CYCLES + 1);
	localparam logic [CW-1:0] STAB_LOAD = CW'(STAB_CYCLES - 1);

	// ------------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------------
	logic        awFull_q, awFull_d, wFull_q, wFull_d;
	logic [7:0]  awAddr_q, awAddr_d;
	logic [31:0] wData_q, wData_d;
	logic [3:0]  wStrb_q, wStrb_d;
	logic        awReady_q, awReady_d, wReady_q, wReady_d;
	logic        bValid_q, bValid_d, arReady_q, arReady_d;
	logic        rValid_q, rValid_d;
	logic [1:0]  bResp_q, bResp_d, rResp_q, rResp_d;
	logic [31:0] rData_q, rData_d;
	logic [3:0]  ctrl_q, ctrl_d;

	lpm_pkg::lpm_state_t state_q, state_d;
	logic [CW-1:0] count_q, count_d;
	logic          causeRst_q, causeRst_d;

	function automatic logic [31:0] status_word(
		input lpm_pkg::lpm_state_t st,
		input logic                cause,
		input logic [CW-1:0]       cnt
	);
		logic [31:0] w;
		w = 32'h0;
		w[lpm_pkg::STATUS_STATE_LSB +: 6] = st;
		w[lpm_pkg::STATUS_CAUSE_BIT] = cause;
		w[lpm_pkg::STATUS_COUNT_LSB +: CW] = cnt;
		return w;
	endfunction : status_word

	always_comb begin
		logic awHit;
		logic wHit;
		awHit     = s_axi_awvalid & awReady_q;
		wHit      = s_axi_wvalid & wReady_q;
		awFull_d  = awFull_q | awHit;
		wFull_d   = wFull_q | wHit;
		awAddr_d  = awHit ? s_axi_awaddr : awAddr_q;
		wData_d   = wHit ? s_axi_wdata : wData_q;
		wStrb_d   = wHit ? s_axi_wstrb : wStrb_q;
		bValid_d  = bValid_q & ~s_axi_bready;
		bResp_d   = bResp_q;
		ctrl_d    = ctrl_q;
		// One write at a time: the next waits until the answer is taken
		if (awFull_d && wFull_d && !bValid_d) begin
			bValid_d = 1'b1;
			awFull_d = 1'b0;
			wFull_d  = 1'b0;
			if (awAddr_d == lpm_pkg::CTRL_OFFSET) begin
				bResp_d = lpm_pkg::RESP_OKAY;
				if (wStrb_d[0]) begin
					ctrl_d = wData_d[3:0];
				end
			end else if (awAddr_d == lpm_pkg::STATUS_OFFSET) begin
				bResp_d = lpm_pkg::RESP_OKAY;
			end else begin
				bResp_d = lpm_pkg::RESP_SLVERR;
			end
		end
		awReady_d = ~awFull_d;
		wReady_d  = ~wFull_d;

		rValid_d = rValid_q & ~s_axi_rready;
		rData_d  = rData_q;
		rResp_d  = rResp_q;
		if (s_axi_arvalid && arReady_q) begin
			rValid_d = 1'b1;
			rResp_d  = lpm_pkg::RESP_OKAY;
			if (s_axi_araddr == lpm_pkg::CTRL_OFFSET) begin
				rData_d = {28'h0, ctrl_q};
			end else if (s_axi_araddr == lpm_pkg::STATUS_OFFSET) begin
				rData_d = status_word(state_q, causeRst_q, count_q);
			end else begin
				rData_d = 32'h0;
				rResp_d = lpm_pkg::RESP_SLVERR;
			end
		end
		arReady_d = ~rValid_d;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			awFull_q  <= 1'b0;
			wFull_q   <= 1'b0;
			awAddr_q  <= 8'h00;
			wData_q   <= 32'h0;
			wStrb_q   <= 4'h0;
			awReady_q <= 1'b0;
			wReady_q  <= 1'b0;
			bValid_q  <= 1'b0;
			bResp_q   <= lpm_pkg::RESP_OKAY;
			arReady_q <= 1'b0;
			rValid_q  <= 1'b0;
			rResp_q   <= lpm_pkg::RESP_OKAY;
			rData_q   <= 32'h0;
			ctrl_q    <= lpm_pkg::CTRL_RESET;
		end else begin
			awFull_q  <= awFull_d;
			wFull_q   <= wFull_d;
			awAddr_q  <= awAddr_d;
			wData_q   <= wData_d;
			wStrb_q   <= wStrb_d;
			awReady_q <= awReady_d;
			wReady_q  <= wReady_d;
			bValid_q  <= bValid_d;
			bResp_q   <= bResp_d;
			arReady_q <= arReady_d;
			rValid_q  <= rValid_d;
			rResp_q   <= rResp_d;
			rData_q   <= rData_d;
			ctrl_q    <= ctrl_d;
		end
	end

	assign s_axi_awready = awReady_q;
	assign s_axi_wready  = wReady_q;
	assign s_axi_bvalid  = bValid_q;
	assign s_axi_bresp   = bResp_q;
	assign s_axi_arready = arReady_q;
	assign s_axi_rvalid  = rValid_q;
	assign s_axi_rresp   = rResp_q;
	assign s_axi_rdata   = rData_q;

	// ------------------------------------------------------------------
	// Power state machine
	// ------------------------------------------------------------------
	logic cpuEn_q, cpuEn_d, perEn_q, perEn_d, osc_q, osc_d;
	logic tbEn_q, tbEn_d, slow_q, slow_d, mClr_q, mClr_d;
	logic svc_q, svc_d, rstVec_q, rstVec_d, wdRst_q, wdRst_d;
	logic wdSusp_q, wdSusp_d;

	always_comb begin
		logic tbIe;
		logic slowOn;
		logic wdOk;
		logic wdOn;
		tbIe   = ctrl_q[lpm_pkg::CTRL_TB_IRQ_EN_BIT];
		slowOn = ctrl_q[lpm_pkg::CTRL_SLOW_BIT];
		wdOk   = ctrl_q[lpm_pkg::CTRL_WDG_HALT_BIT];
		wdOn   = ctrl_q[lpm_pkg::CTRL_WDG_EN_BIT];
		state_d    = state_q;
		count_d    = count_q;
		causeRst_d = causeRst_q;
		mClr_d     = 1'b0;
		svc_d      = 1'b0;
		rstVec_d   = 1'b0;
		wdRst_d    = 1'b0;
		unique case (state_q)
			lpm_pkg::ST_RUN: begin
				if (waitForInterruptInstr) begin
					mClr_d  = 1'b1;
					state_d = slowOn ? lpm_pkg::ST_SLOW_WAIT
					                 : lpm_pkg::ST_WAIT;
				end else if (haltInstr) begin
					if (tbIe) begin
						mClr_d  = 1'b1;
						state_d = lpm_pkg::ST_ACT_HALT;
					end else if (wdOn && !wdOk) begin
						// Halt refused: watchdog option forbids it
						wdRst_d = 1'b1;
					end else begin
						mClr_d  = 1'b1;
						state_d = lpm_pkg::ST_HALT;
					end
				end
			end
			lpm_pkg::ST_WAIT, lpm_pkg::ST_SLOW_WAIT: begin
				// No start-up delay: oscillator never stopped
				if (resetReq) begin
					rstVec_d = 1'b1;
					state_d  = lpm_pkg::ST_RUN;
				end else if (extIrq | timebaseIrq | clockSecIrq
				             | periphIrq) begin
					svc_d   = 1'b1;
					state_d = lpm_pkg::ST_RUN;
				end
			end
			lpm_pkg::ST_ACT_HALT: begin
				if (resetReq | extIrq | timebaseIrq | clockSecIrq) begin
					causeRst_d = resetReq;
					count_d    = STAB_LOAD;
					state_d    = lpm_pkg::ST_STARTUP;
				end
			end
			lpm_pkg::ST_HALT: begin
				if (resetReq | extIrq) begin
					causeRst_d = resetReq;
					count_d    = STAB_LOAD;
					state_d    = lpm_pkg::ST_STARTUP;
				end
			end
			lpm_pkg::ST_STARTUP: begin
				if (count_q == '0) begin
					rstVec_d = causeRst_q;
					svc_d    = ~causeRst_q;
					state_d  = lpm_pkg::ST_RUN;
				end else begin
					count_d = count_q - CW'(1);
				end
			end
			default: begin
				state_d = lpm_pkg::ST_RUN;
			end
		endcase
		cpuEn_d  = (state_d == lpm_pkg::ST_RUN);
		perEn_d  = (state_d == lpm_pkg::ST_RUN)
		         | (state_d == lpm_pkg::ST_WAIT)
		         | (state_d == lpm_pkg::ST_SLOW_WAIT);
		osc_d    = (state_d != lpm_pkg::ST_HALT);
		tbEn_d   = osc_d;
		slow_d   = slowOn & perEn_d;
		// Watchdog frozen in active halt and full halt so it cannot fire
		wdSusp_d = (state_d == lpm_pkg::ST_ACT_HALT)
		         | (state_d == lpm_pkg::ST_HALT);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q    <= lpm_pkg::ST_RUN;
			count_q    <= '0;
			causeRst_q <= 1'b0;
			cpuEn_q    <= 1'b1;
			perEn_q    <= 1'b1;
			osc_q      <= 1'b1;
			tbEn_q     <= 1'b1;
			slow_q     <= 1'b0;
			mClr_q     <= 1'b0;
			svc_q      <= 1'b0;
			rstVec_q   <= 1'b0;
			wdRst_q    <= 1'b0;
			wdSusp_q   <= 1'b0;
		end else begin
			state_q    <= state_d;
			count_q    <= count_d;
			causeRst_q <= causeRst_d;
			cpuEn_q    <= cpuEn_d;
			perEn_q    <= perEn_d;
			osc_q      <= osc_d;
			tbEn_q     <= tbEn_d;
			slow_q     <= slow_d;
			mClr_q     <= mClr_d;
			svc_q      <= svc_d;
			rstVec_q   <= rstVec_d;
			wdRst_q    <= wdRst_d;
			wdSusp_q   <= wdSusp_d;
		end
	end

	assign cpuClkEn         = cpuEn_q;
	assign periphClkEn      = perEn_q;
	assign oscEnable        = osc_q;
	assign timebaseClkEn    = tbEn_q;
	assign slowClkSel       = slow_q;
	assign intMaskClear     = mClr_q;
	assign serviceIrq       = svc_q;
	assign fetchResetVector = rstVec_q;
	assign watchdogReset    = wdRst_q;
	assign watchdogSuspend  = wdSusp_q;

endmodule : lpm_controller

// file: tb/lpm_controller_assertions.sv
// Port checker for the low power mode controller.
// Assumes one clock domain and srst synchronous, active high.
`timescale 1ns/1ps
module lpm_controller_assertions #(
	parameter int STAB_CYCLES = lpm_pkg::STAB_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic waitForInterruptInstr,
	input wire logic haltInstr,
	input wire logic extIrq,
	input wire logic timebaseIrq,
	input wire logic clockSecIrq,
	input wire logic periphIrq,
	input wire logic resetReq,
	input wire logic cpuClkEn,
	input wire logic periphClkEn,
	input wire logic oscEnable,
	input wire logic timebaseClkEn,
	input wire logic intMaskClear,
	input wire logic serviceIrq,
	input wire logic fetchResetVector,
	input wire logic watchdogReset,
	input wire logic watchdogSuspend
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic        inStart;
	logic        vec;
	logic [15:0] stupQ;
	logic [15:0] stupD;
	assign inStart = oscEnable && !cpuClkEn && !periphClkEn
		&& !watchdogSuspend;
	assign vec = serviceIrq || fetchResetVector;
	// Length of the start-up run, seen at the vector pulse
	always_comb stupD = inStart ? stupQ + 16'h0001 : 16'h0000;
	always_ff @(posedge clk) stupQ <= srst ? 16'h0000 : stupD;
	sequence s_wait;
		periphClkEn && !cpuClkEn;
	endsequence
	sequence s_act;
		watchdogSuspend && oscEnable;
	endsequence
	chk_wait_entry: assert property (cpuClkEn && waitForInterruptInstr
		|=> s_wait ##0 intMaskClear) else $error("bad wait entry");
	chk_halt_entry: assert property (cpuClkEn
		&& haltInstr && !waitForInterruptInstr |=> watchdogReset
		|| (intMaskClear && !cpuClkEn && !periphClkEn
		&& watchdogSuspend)) else $error("bad halt entry");
	chk_wait_wake: assert property (s_wait
		##0 (extIrq || timebaseIrq || clockSecIrq || periphIrq
		|| resetReq) |=> cpuClkEn && vec) else $error("wait wake late");
	chk_act_hold: assert property (s_act ##0 !(extIrq || timebaseIrq
		|| clockSecIrq || resetReq) |=> s_act) else $error("active halt left");
	chk_halt_hold: assert property (!oscEnable && !extIrq && !resetReq
		|=> !oscEnable) else $error("full halt left");
	chk_halt_wake: assert property (watchdogSuspend && (extIrq || resetReq)
		|=> inStart) else $error("no oscillator start");
	chk_stab_count: assert property (vec && stupQ != 16'h0000
		|-> stupQ == STAB_CYCLES) else $error("start-up length wrong");
	chk_halt_gates: assert property (!oscEnable
		|-> !cpuClkEn && !periphClkEn && !timebaseClkEn)
		else $error("clock in halt");
	chk_act_gates: assert property (s_act
		|-> timebaseClkEn && !periphClkEn && !cpuClkEn) else $error("active gates");
	chk_wdg_quiet: assert property (watchdogSuspend
		|-> !watchdogReset) else $error("watchdog reset in halt");
endmodule : lpm_controller_assertions

// file: tb/lpm_cpu_model.sv
// CPU core stand-in holding the condition-code interrupt mask.
// Assumes the controller's mask and vector strobes are one cycle wide.
`timescale 1ns/1ps
module lpm_cpu_model (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic intMaskClear,
	input  wire logic serviceIrq,
	input  wire logic fetchResetVector,
	output logic      iMaskQ
);
	logic iMaskD;
	always_comb begin
		iMaskD = iMaskQ;
		if (intMaskClear)
			iMaskD = 1'h0;
		// Vector entry wins: the routine runs masked
		if (serviceIrq || fetchResetVector)
			iMaskD = 1'h1;
	end
	always_ff @(posedge clk) iMaskQ <= srst ? 1'h1 : iMaskD;
endmodule : lpm_cpu_model

// file: tb/lpm_controller_tb.sv
// Bench for the low power mode controller: bus, wait and halt runs.
// Assumes a short start-up count so halt exits stay brief.
`timescale 1ns/1ps
module lpm_controller_tb;
	localparam int STAB = 8;
	logic        clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready, iMaskQ;
	logic        waitForInterruptInstr, haltInstr, extIrq, timebaseIrq;
	logic        clockSecIrq, periphIrq, resetReq, cpuClkEn, periphClkEn;
	logic        oscEnable, timebaseClkEn, slowClkSel, intMaskClear;
	logic        serviceIrq, fetchResetVector, watchdogReset, watchdogSuspend;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	int          nMismatch, testsRun;
	lpm_controller #(.STAB_CYCLES(STAB)) dut (.*);
	lpm_cpu_model cpu (.*);
	always #50 clk = ~clk;
	task automatic stop_test();
		$display("checks %0d mismatches %0d", testsRun, nMismatch);
		if (nMismatch == 0 && testsRun > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task automatic check(input string what, input logic [31:0] seen, exp);
		testsRun++;
		if (seen !== exp) begin
			nMismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic guard(input int n);
		if (n >= 50) begin
			nMismatch++;
			stop_test();
		end
	endtask : guard
	// ------------------------------------------------------------
	// Bus cycles: payload held until its own ready is seen
	// ------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid && n < 50);
		guard(n);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		int n;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid && n < 50);
		guard(n);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : axi_rd
	// Wait instruction when w is set, halt otherwise; ends settled
	task automatic instr(input logic w);
		@(posedge clk);
		if (w) waitForInterruptInstr <= 1'h1;
		else haltInstr <= 1'h1;
		@(posedge clk);
		waitForInterruptInstr <= 1'h0;
		haltInstr <= 1'h0;
		@(negedge clk);
	endtask : instr
	// Source 0 ext, 1 timebase, 2 clock security, 3 periph, 4 reset
	task automatic wake(input int s, n0, input logic v, rv);
		int n;
		@(posedge clk);
		{resetReq, periphIrq, clockSecIrq, timebaseIrq, extIrq} <= 5'h01 << s;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!(serviceIrq || fetchResetVector) && n < n0);
		check("woke", serviceIrq || fetchResetVector, v);
		check("by reset", fetchResetVector, rv);
		check("cycles", n, n0);
		@(posedge clk);
		{resetReq, periphIrq, clockSecIrq, timebaseIrq, extIrq} <= 5'h00;
		@(negedge clk);
	endtask : wake
	initial begin
		{clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
		{s_axi_rready, waitForInterruptInstr, haltInstr} = 3'h0;
		{extIrq, timebaseIrq, clockSecIrq, periphIrq, resetReq} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		srst = 1'h1;
		repeat (20) @(posedge clk);
		srst <= 1'h0;
		axi_rd(lpm_pkg::CTRL_OFFSET);
		check("ctrl reset", d, 32'h0);
		axi_rd(lpm_pkg::STATUS_OFFSET);
		check("status reset", d & 32'h7F, 32'h01);
		axi_rd(8'h08);
		check("unmapped rd", {d[29:0], r}, lpm_pkg::RESP_SLVERR);
		axi_wr(8'h08, 32'hF);
		check("unmapped wr", r, lpm_pkg::RESP_SLVERR);
		axi_wr(lpm_pkg::STATUS_OFFSET, 32'hF);
		check("status wr", r, lpm_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'hE;
		axi_wr(lpm_pkg::CTRL_OFFSET, 32'hF);
		s_axi_wstrb <= 4'hF;
		axi_rd(lpm_pkg::CTRL_OFFSET);
		check("strobe off", d, 32'h0);
		$display("end of register test");
		instr(1'h1);
		check("cpu clk", cpuClkEn, 1'h0);
		check("periph clk", periphClkEn, 1'h1);
		check("mask clear", intMaskClear, 1'h1);
		wake(3, 2, 1'h1, 1'h0);
		check("mask set", iMaskQ, 1'h1);
		axi_wr(lpm_pkg::CTRL_OFFSET, 32'h2);
		instr(1'h1);
		check("slow clk", slowClkSel, 1'h1);
		axi_rd(lpm_pkg::STATUS_OFFSET);
		check("slow wait", d & 32'h7F, 32'h04);
		wake(4, 2, 1'h1, 1'h1);
		$display("end of wait test");
		axi_wr(lpm_pkg::CTRL_OFFSET, 32'h9);
		axi_rd(lpm_pkg::CTRL_OFFSET);
		check("ctrl", d, 32'h9);
		instr(1'h0);
		check("tb clk", {timebaseClkEn, periphClkEn}, 2'h2);
		check("no wdg", {watchdogReset, watchdogSuspend, intMaskClear}, 3'h3);
		wake(3, 4, 1'h0, 1'h0);
		wake(1, STAB + 2, 1'h1, 1'h0);
		$display("end of active halt test");
		axi_wr(lpm_pkg::CTRL_OFFSET, 32'h8);
		instr(1'h0);
		check("refused", {watchdogReset, cpuClkEn}, 2'h3);
		axi_wr(lpm_pkg::CTRL_OFFSET, 32'hC);
		instr(1'h0);
		check("osc off", {oscEnable, intMaskClear}, 2'h1);
		wake(1, 4, 1'h0, 1'h0);
		wake(2, 4, 1'h0, 1'h0);
		wake(0, STAB + 2, 1'h1, 1'h0);
		instr(1'h0);
		wake(4, STAB + 2, 1'h1, 1'h1);
		axi_rd(lpm_pkg::STATUS_OFFSET);
		check("reset cause", d & 32'h7F, 32'h41);
		$display("end of halt test");
		stop_test();
	end
endmodule : lpm_controller_tb
bind lpm_controller lpm_controller_assertions #(
	.STAB_CYCLES(STAB_CYCLES)
) chk (.*);
